// File: rtl/fws_map.vh
// Purpose: Constants for the flash write-status polling controller
// Assumes: 50 MHz clock, 8-bit data bus to the flash
// Notes:   Bit positions of status bits, bus timing counts, result codes
`ifndef FWS_MAP_VH
`define FWS_MAP_VH
// Status bit positions on the data bus
`define FWS_POLL_BIT     7
`define FWS_TOGGLE1_BIT  6
`define FWS_TLIMIT_BIT   5
`define FWS_TOGGLE2_BIT  2
// Bus timing: read strobe low time and gap, in ns, and derived cycles
`define FWS_CLK_NS       20
`define FWS_RD_LOW_NS    100
`define FWS_RD_LOW_CYC   ((`FWS_RD_LOW_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RD_GAP_NS    60
`define FWS_RD_GAP_CYC   ((`FWS_RD_GAP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
// Result codes
`define FWS_RES_OK       2'h0
`define FWS_RES_FAIL     2'h1
`define FWS_RES_SUSP     2'h2
// Polling modes
`define FWS_MODE_POLL    1'h0
`define FWS_MODE_TOGGLE  1'h1
// Reset command data for the flash
`define FWS_RESET_CMD    8'hf0
`endif

// File: rtl/fws_poll_ctrl.v
// Purpose: Host-side controller that polls a flash for program/erase completion
// Assumes: Flash pins are asynchronous; data input is sampled via two flip-flops
// Notes:   Uses complement polling or toggle-bit polling; issues reset on failure
//
// Summary of operation
// - Host reads status at the address being programmed.
// - Host reads erase status inside a selected or unprotected sector.
// - After bit 7 turns true, host trusts full byte only next read.
// - Host compares both toggle bits to learn sector and suspend state.
// - On timing-limit flag, host reads status once more before failing.
// - After failure the host issues the reset command.
`timescale 1ns/1ns
`include "fws_map.vh"
module fws_poll_ctrl (
  // Clock and reset
  input  wire        mclk_in,
  input  wire        resetn_in,
  // User command port
  input  wire        start_in,
  input  wire        mode_in,
  input  wire [17:0] addr_in,
  input  wire [7:0]  expect_in,
  output reg         busy_out,
  output reg         done_out,
  output reg  [1:0]  result_out,
  output reg  [7:0]  data_out,
  // Flash pins
  output reg  [17:0] flash_addr_out,
  input  wire [7:0]  flash_dq_in,
  output reg  [7:0]  flash_dq_out,
  output reg         flash_dq_oe_out,
  output reg         flash_ce_n_out,
  output reg         flash_oe_n_out,
  output reg         flash_we_n_out,
  input  wire        flash_ready_busy_n_in
);
  // Sequencer states
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_RD   = 3'h1;
  localparam [2:0] ST_GAP  = 3'h2;
  localparam [2:0] ST_EVAL = 3'h3;
  localparam [2:0] ST_RST  = 3'h4;
  localparam [2:0] ST_DONE = 3'h5;
  // Bus timing counts, cut to the counter width on purpose
  localparam integer RD_LOW_I = `FWS_RD_LOW_CYC;
  localparam integer RD_GAP_I = `FWS_RD_GAP_CYC;
  localparam [3:0]   RD_LOW   = RD_LOW_I[3:0];
  localparam [3:0]   RD_GAP   = RD_GAP_I[3:0];

  reg  [2:0] state_q;
  reg  [3:0] cnt_q;
  reg  [7:0] dq_s1_q;
  reg  [7:0] dq_s2_q;
  reg        rb_s1_q;
  reg        rb_s2_q;
  reg  [7:0] prev_q;
  reg        have_prev_q;
  reg        tlim_seen_q;
  reg        confirm_q;
  reg        mode_q;
  reg  [7:0] exp_q;
  reg        susp_q;

  // Pin synchronisers; first stage feeds only the second
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
      rb_s1_q <= 1'h1;
      rb_s2_q <= 1'h1;
    end else begin
      dq_s1_q <= flash_dq_in;
      dq_s2_q <= dq_s1_q;
      rb_s1_q <= flash_ready_busy_n_in;
      rb_s2_q <= rb_s1_q;
    end
  end

  // Status bit decode from the synchronised byte
  wire poll_true = (dq_s2_q[`FWS_POLL_BIT] == exp_q[`FWS_POLL_BIT]);
  wire t1_same   = (dq_s2_q[`FWS_TOGGLE1_BIT] == prev_q[`FWS_TOGGLE1_BIT]);
  wire tlim      = dq_s2_q[`FWS_TLIMIT_BIT];
  wire t2_moves  = (dq_s2_q[`FWS_TOGGLE2_BIT] != prev_q[`FWS_TOGGLE2_BIT]);

  // Main sequencer: read cycles, evaluation, reset command
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q         <= ST_IDLE;
      cnt_q           <= 4'h0;
      prev_q          <= 8'h00;
      have_prev_q     <= 1'h0;
      tlim_seen_q     <= 1'h0;
      confirm_q       <= 1'h0;
      mode_q          <= `FWS_MODE_POLL;
      exp_q           <= 8'h00;
      susp_q          <= 1'h0;
      busy_out        <= 1'h0;
      done_out        <= 1'h0;
      result_out      <= `FWS_RES_OK;
      data_out        <= 8'h00;
      flash_addr_out  <= 18'h00000;
      flash_dq_out    <= 8'h00;
      flash_dq_oe_out <= 1'h0;
      flash_ce_n_out  <= 1'h1;
      flash_oe_n_out  <= 1'h1;
      flash_we_n_out  <= 1'h1;
    end else begin
      done_out <= 1'h0;
      case (state_q)
        ST_IDLE: begin
          // Start only after the command's last write strobe has risen
          if (start_in) begin
            mode_q         <= mode_in;
            exp_q          <= expect_in;
            flash_addr_out <= addr_in;
            have_prev_q    <= 1'h0;
            tlim_seen_q    <= 1'h0;
            confirm_q      <= 1'h0;
            susp_q         <= 1'h0;
            busy_out       <= 1'h1;
            cnt_q          <= 4'h0;
            state_q        <= ST_RD;
          end
        end
        ST_RD: begin
          // Read cycle with chip and output enable low
          flash_ce_n_out <= 1'h0;
          flash_oe_n_out <= 1'h0;
          if (cnt_q == RD_LOW + 4'h2) begin // Extra cycles cover the synchroniser
            flash_ce_n_out <= 1'h1;
            flash_oe_n_out <= 1'h1;
            cnt_q          <= 4'h0;
            state_q        <= ST_EVAL;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_EVAL: begin
          prev_q      <= dq_s2_q;
          have_prev_q <= 1'h1;
          state_q     <= ST_GAP;
          if (confirm_q) begin
            // Byte after polling bit turned true is now trusted
            // Suspend stands only if toggle two moves again with toggle one still
            data_out   <= dq_s2_q;
            if (mode_q == `FWS_MODE_TOGGLE && susp_q && t1_same && t2_moves) begin
              result_out <= `FWS_RES_SUSP;
            end else begin
              result_out <= `FWS_RES_OK;
            end
            state_q    <= ST_DONE;
          end else if (mode_q == `FWS_MODE_POLL) begin
            if (poll_true) begin
              confirm_q <= 1'h1;
            end else if (tlim_seen_q) begin
              result_out <= `FWS_RES_FAIL;
              state_q    <= ST_RST;
            end else if (tlim) begin
              tlim_seen_q <= 1'h1;
            end
          end else if (have_prev_q) begin
            if (t1_same) begin
              // Stopped toggling: done, or suspended if toggle two still moves and the synchronised ready/busy pin reads ready
              susp_q     <= t2_moves && rb_s2_q;
              confirm_q  <= 1'h1;
            end else if (tlim_seen_q) begin
              result_out <= `FWS_RES_FAIL;
              state_q    <= ST_RST;
            end else if (tlim) begin
              tlim_seen_q <= 1'h1;
            end
          end
        end
        ST_GAP: begin
          // Recovery between read cycles
          if (cnt_q == RD_GAP) begin
            cnt_q   <= 4'h0;
            state_q <= ST_RD;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_RST: begin
          // Write the reset command to return to array reads
          flash_dq_out    <= `FWS_RESET_CMD;
          flash_dq_oe_out <= 1'h1;
          flash_ce_n_out  <= 1'h0;
          flash_we_n_out  <= 1'h0;
          if (cnt_q == RD_LOW) begin
            flash_we_n_out  <= 1'h1;
            flash_ce_n_out  <= 1'h1;
            cnt_q           <= 4'h0;
            state_q         <= ST_DONE;
          end else begin
            cnt_q <= cnt_q + 4'h1;
          end
        end
        ST_DONE: begin
          // Report result and release the bus
          flash_dq_oe_out <= 1'h0;
          busy_out        <= 1'h0;
          done_out        <= 1'h1;
          state_q         <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end
endmodule // fws_poll_ctrl

// File: sim/fws_poll_monitor.sv
// Purpose: Port checks on the polling controller
// Assumes: One clock, async active-low reset
// Notes:   Bound from the bench
`timescale 1ns/1ns
module fws_poll_monitor (
  input wire        mclk_in, resetn_in, start_in, busy_out, done_out,
  input wire [1:0]  result_out,
  input wire        flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_dq_oe_out,
  input wire [7:0]  flash_dq_out,
  input wire [17:0] addr_in, flash_addr_out
);
  logic [17:0] addr_q;
  logic [1:0]  rd_q;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Status address and read count of one poll
  always @(posedge mclk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      addr_q <= 18'h0;
      rd_q <= 2'h0;
    end else if (start_in && !busy_out) begin
      addr_q <= addr_in;
      rd_q <= 2'h0;
    end else if ($fell(flash_oe_n_out) && rd_q != 2'h3) begin
      rd_q <= rd_q + 2'h1;
    end
  end
  chk_start_busy: assert property (start_in && !busy_out |=> busy_out)
    else $error("busy late");
  chk_done_pulse: assert property (done_out |=> !done_out && !busy_out)
    else $error("done too long");
  chk_read_len: assert property ($fell(flash_oe_n_out) |-> !flash_oe_n_out [*7] ##1 flash_oe_n_out)
    else $error("read length");
  chk_read_addr: assert property (!flash_oe_n_out |-> !flash_ce_n_out && flash_addr_out == addr_q)
    else $error("read address");
  chk_reset_cmd: assert property (!flash_we_n_out |-> flash_dq_oe_out && flash_dq_out == 8'hf0)
    else $error("reset data");
  chk_fail_code: assert property ($fell(flash_we_n_out) |-> ##[1:16] done_out && result_out == 2'h1)
    else $error("fail code");
  chk_two_reads: assert property (done_out |-> rd_q >= 2'h2)
    else $error("one read");
  chk_idle_quiet: assert property (!busy_out |-> flash_ce_n_out && flash_oe_n_out && flash_we_n_out)
    else $error("idle bus");
  cover property (done_out && result_out == 2'h0);
  cover property (done_out && result_out == 2'h1);
  cover property (done_out && result_out == 2'h2);
endmodule // fws_poll_monitor

// File: sim/fws_flash_model.sv
// Purpose: Behavioural flash status model
// Assumes: Bench sets op, cnt and arr
// Notes:   op 0 program, 1 erase, 2 suspended, 3 timing fail
`timescale 1ns/1ns
module fws_flash_model (
  input  wire        flash_ce_n_out, flash_oe_n_out, flash_we_n_out,
  input  wire  [7:0] flash_dq_out,
  output logic [7:0] m_dq,
  output wire        rb_low
);
  logic [7:0] arr = 8'h0;
  logic [1:0] op = 2'h0;
  logic       t1 = 1'b0;
  logic       t2 = 1'b0;
  int         cnt = 0;
  // Busy pin pulls low unless suspended
  assign rb_low = cnt > 0 && op != 2'h2;
  // Status while busy, array data after
  always @(negedge flash_oe_n_out) if (!flash_ce_n_out) begin
    if (cnt > 0) begin
      t1 = (op == 2'h2) ? t1 : !t1;
      t2 = (op != 2'h0) ? !t2 : t2;
      m_dq = {op == 2'h0 ? !arr[7] : op == 2'h2, t1, op == 2'h3, 2'h0, t2, 2'h0};
      cnt = (op < 2'h2) ? cnt - 1 : cnt;
    end else
      m_dq = arr;
  end
  // Released bus shows the inverse
  always @(posedge flash_oe_n_out) m_dq = ~m_dq;
  // Reset command ends the operation
  always @(negedge flash_we_n_out) #5 if (flash_dq_out == 8'hf0) cnt = 0;
endmodule // fws_flash_model

// File: sim/test_fws_poll_ctrl.sv
// Purpose: Self-checking bench for the polling controller
// Assumes: Model on the flash pins
// Notes:   Random runs from seed 94
`timescale 1ns/1ns
module test_fws_poll_ctrl;
  logic        mclk_in = 1'b0, resetn_in = 1'b0, start_in = 1'b0, mode_in = 1'b0;
  logic [17:0] addr_in = 18'h0;
  logic [7:0]  expect_in = 8'h0;
  wire         busy_out, done_out, flash_dq_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, rb_low;
  wire [1:0]   result_out;
  wire [7:0]   data_out, flash_dq_out, flash_dq_in, m_dq;
  wire [17:0]  flash_addr_out;
  wire         flash_ready_busy_n_in = !rb_low;
  int          bad_count = 0, n_checks = 0;
  fws_poll_ctrl DUT (
    .mclk_in               (mclk_in),
    .resetn_in             (resetn_in),
    .start_in              (start_in),
    .mode_in               (mode_in),
    .addr_in               (addr_in),
    .expect_in             (expect_in),
    .busy_out              (busy_out),
    .done_out              (done_out),
    .result_out            (result_out),
    .data_out              (data_out),
    .flash_addr_out        (flash_addr_out),
    .flash_dq_in           (flash_dq_in),
    .flash_dq_out          (flash_dq_out),
    .flash_dq_oe_out       (flash_dq_oe_out),
    .flash_ce_n_out        (flash_ce_n_out),
    .flash_oe_n_out        (flash_oe_n_out),
    .flash_we_n_out        (flash_we_n_out),
    .flash_ready_busy_n_in (flash_ready_busy_n_in)
  );
  fws_flash_model u_flash (
    .flash_ce_n_out (flash_ce_n_out),
    .flash_oe_n_out (flash_oe_n_out),
    .flash_we_n_out (flash_we_n_out),
    .flash_dq_out   (flash_dq_out),
    .m_dq           (m_dq),
    .rb_low         (rb_low)
  );
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : m_dq;
  always #10 mclk_in = ~mclk_in;
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task results;
    if (bad_count == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  function logic [1:0] exp_res(input logic [1:0] op, input logic md);
    return (op == 2'h3) ? 2'h1 : (op == 2'h2 && md) ? 2'h2 : 2'h0;
  endfunction
  // One poll: load the model, start, wait for done, compare
  task run(input logic [1:0] op, input int cnt, input logic md);
    int i;
    u_flash.op = op;
    u_flash.cnt = cnt;
    u_flash.arr = (op == 2'h0) ? 8'($urandom) : 8'hff;
    start_in = 1'b1;
    mode_in = md;
    addr_in = 18'($urandom);
    expect_in = u_flash.arr;
    @(posedge mclk_in);
    #2 start_in = 1'b0;
    i = 0;
    while (done_out !== 1'b1 && i < 4000) begin
      @(posedge mclk_in);
      #1 i++;
    end
    check({7'h00, done_out}, 8'h01);
    check(result_out, exp_res(op, md));
    if (op < 2'h2) check(data_out, u_flash.arr);
    @(posedge mclk_in);
    #2;
  endtask
  initial begin
    void'($urandom(94));
    repeat (5) @(posedge mclk_in);
    #2 resetn_in = 1'b1;
    check({busy_out, done_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_dq_oe_out}, 8'h0e);
    for (int k = 0; k < 24; k++)
      run(2'(k % 4), 1 + $urandom % 5, k[2]);
    run(2'h0, 0, 1'b0);
    results;
  end
  // Watchdog well past the expected run time
  initial begin
    #1000000;
    bad_count++;
    results;
  end
endmodule // test_fws_poll_ctrl
bind fws_poll_ctrl fws_poll_monitor u_mon (
  .mclk_in         (mclk_in),
  .resetn_in       (resetn_in),
  .start_in        (start_in),
  .busy_out        (busy_out),
  .done_out        (done_out),
  .result_out      (result_out),
  .flash_ce_n_out  (flash_ce_n_out),
  .flash_oe_n_out  (flash_oe_n_out),
  .flash_we_n_out  (flash_we_n_out),
  .flash_dq_oe_out (flash_dq_oe_out),
  .flash_dq_out    (flash_dq_out),
  .addr_in         (addr_in),
  .flash_addr_out  (flash_addr_out)
);
